// *** rtl/dua_pkg.sv ***
// Shared constants and types for the dual serial channel host port.
package dua_pkg;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int RESET_PULSE_NS = 40;
	localparam int RESET_PULSE_CYC =
		(RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 3;
	localparam logic [RST_CNT_W-1:0] RST_CNT_FULL =
		RESET_PULSE_CYC[RST_CNT_W-1:0];

	localparam int NUM_CH     = 2;
	localparam int MEM_ADDR_W = 4;
	localparam int MEM_DEPTH  = 16;

	localparam logic [2:0] OFS_HOLDING      = 3'h0;
	localparam logic [2:0] OFS_INT_ENABLE   = 3'h1;
	localparam logic [2:0] OFS_ENH_FEATURE  = 3'h2;
	localparam logic [2:0] OFS_MODEM_CTRL   = 3'h4;
	localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;
	localparam logic [2:0] OFS_IR_CONFIG    = 3'h7;

	localparam int MCR_DTR      = 0;
	localparam int MCR_RTS      = 1;
	localparam int MCR_OP2      = 3;
	localparam int MCR_IR       = 6;
	localparam int EFR_AUTO_RTS = 6;
	localparam int EFR_AUTO_CTS = 7;
	localparam int IER_RX       = 0;
	localparam int IER_TX       = 1;
	localparam int IRC_RX_INV   = 0;
	localparam int MSR_CTS      = 4;
	localparam int MSR_DSR      = 5;
	localparam int MSR_RI       = 6;
	localparam int MSR_CD       = 7;

	localparam logic [7:0] REG_RESET = 8'h00;

	typedef enum logic [2:0] {
		DUA_IDLE  = 3'b001,
		DUA_READ  = 3'b010,
		DUA_WRITE = 3'b100
	} dua_bus_state_t;
endpackage

// *** rtl/dua_mem_if.sv ***
// Port between the bus logic and the register storage memory.
`timescale 1ns/1ps
`default_nettype none
interface dua_mem_if;
	logic                      wr_en;
	logic [3:0]                wr_addr;
	logic [7:0]                wr_data;
	logic [3:0]                rd_addr;
	logic [7:0]                rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data);
endinterface
`default_nettype wire

// *** rtl/dua_reg_mem.sv ***
// Byte storage for both channels' plain read/write registers.
`timescale 1ns/1ps
`default_nettype none
module dua_reg_mem (
	input  wire logic  ref_clk,
	input  wire logic  rst_b,
	dua_mem_if.mem     port
);
	logic [7:0] store [dua_pkg::MEM_DEPTH];

	genvar i;
	generate
		for (i = 0; i < dua_pkg::MEM_DEPTH; i++) begin : g_ent
			always_ff @(posedge ref_clk) begin
				if (!rst_b) begin
					store[i] <= dua_pkg::REG_RESET;
				end else if (port.wr_en &&
						port.wr_addr == 4'(i)) begin
					store[i] <= port.wr_data;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			port.rd_data <= dua_pkg::REG_RESET;
		end else begin
			port.rd_data <= store[port.rd_addr];
		end
	end
endmodule // dua_reg_mem
`default_nettype wire

// *** rtl/dua_host_port.sv ***
// Host bus port and per-channel pin control of the dual serial device.
`timescale 1ns/1ps
`default_nettype none
module dua_host_port (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        bus_mode_strobe,
	input  wire logic        reset_pin,
	input  wire logic [2:0]  addr,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe_n,
	input  wire logic        read_strobe_n,
	input  wire logic        write_strobe_n,
	input  wire logic        channel_a_select_n,
	input  wire logic        channel_b_select_n,
	output logic             channel_a_irq_out,
	output logic             channel_a_irq_oe_n,
	output logic             channel_b_irq_out,
	output logic             channel_b_irq_oe_n,
	output logic             channel_a_output_port2_n,
	output logic             channel_b_output_port2_n,
	output logic             channel_a_tx_ready_n,
	output logic             channel_b_tx_ready_n,
	output logic             channel_a_rx_ready_n,
	output logic             channel_b_rx_ready_n,
	output logic             channel_a_serial_out,
	output logic             channel_b_serial_out,
	input  wire logic        channel_a_serial_in,
	input  wire logic        channel_b_serial_in,
	output logic             channel_a_request_to_send_n,
	output logic             channel_b_request_to_send_n,
	input  wire logic        channel_a_clear_to_send_n,
	input  wire logic        channel_b_clear_to_send_n,
	output logic             channel_a_terminal_ready_n,
	output logic             channel_b_terminal_ready_n,
	input  wire logic        channel_a_set_ready_n,
	input  wire logic        channel_b_set_ready_n,
	input  wire logic        channel_a_carrier_detect_n,
	input  wire logic        channel_b_carrier_detect_n,
	input  wire logic        channel_a_ring_indicator_n,
	input  wire logic        channel_b_ring_indicator_n,
	input  wire logic [1:0]  tx_taken,
	input  wire logic [1:0]  tx_busy,
	input  wire logic [1:0]  tx_bit,
	output logic      [15:0] tx_byte,
	output logic      [1:0]  tx_allowed,
	input  wire logic [1:0]  rx_push,
	input  wire logic [15:0] rx_byte,
	output logic      [1:0]  rx_line
);
	dua_pkg::dua_bus_state_t state;
	dua_pkg::dua_bus_state_t next_state;

	logic [dua_pkg::RST_CNT_W-1:0] rst_cnt;
	logic        pin_rst_active;
	logic        int_rst;
	logic        mem_rst_b;
	logic        rd_q;
	logic        wr_q;
	logic        cs_q;
	logic        sel_q;
	logic [7:0]  data_q;
	logic        sel_a;
	logic        sel_b;
	logic        access_sel;
	logic        live_chan;
	logic        start_read;
	logic        start_write;
	logic        end_read;
	logic        end_write;
	logic        commit;
	logic        acc_chan;
	logic [2:0]  acc_addr;
	logic        rd_chan;
	logic [2:0]  rd_addr;
	logic [7:0]  read_value;
	logic [1:0]  irq_req;
	logic [1:0]  pin_serial_in;
	logic [1:0]  pin_cts_n;
	logic [1:0]  pin_dsr_n;
	logic [1:0]  pin_cd_n;
	logic [1:0]  pin_ri_n;
	logic [1:0]  irq_out;
	logic [1:0]  irq_oe_n;
	logic [1:0]  op2_n;
	logic [1:0]  tx_rdy_n;
	logic [1:0]  rx_rdy_n;
	logic [1:0]  ser_out;
	logic [1:0]  rts_n;
	logic [1:0]  dtr_n;
	logic [15:0] ch_rd_val;

	dua_mem_if mem_bus ();

	dua_reg_mem u_mem (
		.ref_clk (ref_clk),
		.rst_b   (mem_rst_b),
		.port    (mem_bus)
	);

	// The pin reset only counts once it has been held long enough, so a
	// glitch on the pin cannot clear the channels.
	always_comb begin
		pin_rst_active = bus_mode_strobe ? reset_pin : !reset_pin;
		int_rst = !rst_b ||
			(pin_rst_active && rst_cnt == dua_pkg::RST_CNT_FULL);
		// The pin reset clears the plain storage too, not only the flops.
		mem_rst_b = !int_rst;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b || !pin_rst_active) begin
			rst_cnt <= '0;
		end else if (rst_cnt != dua_pkg::RST_CNT_FULL) begin
			rst_cnt <= rst_cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (int_rst) begin
			rd_q   <= 1'b1;
			wr_q   <= 1'b1;
			cs_q   <= 1'b1;
			sel_q  <= 1'b0;
			data_q <= dua_pkg::REG_RESET;
		end else begin
			rd_q   <= read_strobe_n;
			wr_q   <= write_strobe_n;
			cs_q   <= channel_a_select_n;
			sel_q  <= access_sel;
			data_q <= data_in;
		end
	end

	// Bus style decode; the read strobe is not looked at in line mode.
	// The style pad is pulled up, so a floating pin lands in strobe style.
	always_comb begin
		sel_a = !channel_a_select_n;
		sel_b = !channel_b_select_n;
		if (bus_mode_strobe) begin
			access_sel  = sel_a || sel_b;
			live_chan   = sel_b && !sel_a;
			start_read  = rd_q && !read_strobe_n && access_sel;
			start_write = wr_q && !write_strobe_n && access_sel;
			end_read    = read_strobe_n || !access_sel;
			end_write   = !wr_q && write_strobe_n;
		end else begin
			access_sel  = sel_a;
			live_chan   = channel_b_select_n;
			start_read  = cs_q && sel_a && write_strobe_n;
			start_write = cs_q && sel_a && !write_strobe_n;
			end_read    = !sel_a;
			end_write   = !cs_q && !sel_a;
		end
		commit = (state == dua_pkg::DUA_WRITE) && end_write && sel_q;
	end

	always_comb begin
		next_state = state;
		case (state)
			dua_pkg::DUA_IDLE: begin
				if (start_read) begin
					next_state = dua_pkg::DUA_READ;
				end else if (start_write) begin
					next_state = dua_pkg::DUA_WRITE;
				end
			end
			dua_pkg::DUA_READ: begin
				if (end_read) begin
					next_state = dua_pkg::DUA_IDLE;
				end
			end
			dua_pkg::DUA_WRITE: begin
				if (end_write || !sel_q) begin
					next_state = dua_pkg::DUA_IDLE;
				end
			end
			default: begin
				next_state = dua_pkg::DUA_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (int_rst) begin
			state <= dua_pkg::DUA_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (int_rst) begin
			acc_chan <= 1'b0;
			acc_addr <= 3'h0;
		end else if (state == dua_pkg::DUA_IDLE &&
				(start_read || start_write)) begin
			acc_chan <= live_chan;
			acc_addr <= addr;
		end
	end

	// The storage read port is registered, so the byte offered at the
	// strobe edge relies on the address settling a cycle before it.
	always_comb begin
		rd_chan = (state == dua_pkg::DUA_IDLE) ? live_chan : acc_chan;
		rd_addr = (state == dua_pkg::DUA_IDLE) ? addr : acc_addr;
		read_value = rd_chan ? ch_rd_val[15:8] : ch_rd_val[7:0];
		mem_bus.rd_addr = {rd_chan, rd_addr};
		mem_bus.wr_en   = commit;
		mem_bus.wr_addr = {acc_chan, acc_addr};
		mem_bus.wr_data = data_q;
	end

	always_ff @(posedge ref_clk) begin
		if (int_rst) begin
			data_out <= dua_pkg::REG_RESET;
		end else if (next_state == dua_pkg::DUA_READ) begin
			data_out <= read_value;
		end
	end

	assign data_oe_n = (state != dua_pkg::DUA_READ);

	assign pin_serial_in = {channel_b_serial_in, channel_a_serial_in};
	assign pin_cts_n = {channel_b_clear_to_send_n, channel_a_clear_to_send_n};
	assign pin_dsr_n = {channel_b_set_ready_n, channel_a_set_ready_n};
	assign pin_cd_n  = {channel_b_carrier_detect_n, channel_a_carrier_detect_n};
	assign pin_ri_n  = {channel_b_ring_indicator_n, channel_a_ring_indicator_n};

	genvar ch;
	generate
		for (ch = 0; ch < dua_pkg::NUM_CH; ch++) begin : g_ch
			logic [7:0] ier;
			logic [7:0] enhanced_feature_reg;
			logic [7:0] modem_control_reg;
			logic [7:0] ircfg;
			logic [7:0] tx_hold;
			logic [7:0] rx_hold;
			logic [7:0] msr;
			logic       tx_full;
			logic       rx_full;
			logic       wr_here;
			logic       rd_hold;

			assign wr_here = commit && acc_chan == 1'(ch);
			assign rd_hold = start_read && state == dua_pkg::DUA_IDLE &&
				live_chan == 1'(ch) && addr == dua_pkg::OFS_HOLDING;

			always_ff @(posedge ref_clk) begin
				if (int_rst) begin
					ier   <= dua_pkg::REG_RESET;
					enhanced_feature_reg   <= dua_pkg::REG_RESET;
					modem_control_reg   <= dua_pkg::REG_RESET;
					ircfg <= dua_pkg::REG_RESET;
				end else if (wr_here) begin
					case (acc_addr)
						dua_pkg::OFS_INT_ENABLE:  ier   <= data_q;
						dua_pkg::OFS_ENH_FEATURE: enhanced_feature_reg   <= data_q;
						dua_pkg::OFS_MODEM_CTRL:  modem_control_reg   <= data_q;
						dua_pkg::OFS_IR_CONFIG:   ircfg <= data_q;
						default: ;
					endcase
				end
			end

			// A new byte arriving in the cycle it is taken keeps the flag set.
			always_ff @(posedge ref_clk) begin
				if (int_rst) begin
					tx_full <= 1'b0;
					tx_hold <= dua_pkg::REG_RESET;
				end else if (wr_here && acc_addr == dua_pkg::OFS_HOLDING) begin
					tx_full <= 1'b1;
					tx_hold <= data_q;
				end else if (tx_taken[ch]) begin
					tx_full <= 1'b0;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (int_rst) begin
					rx_full <= 1'b0;
					rx_hold <= dua_pkg::REG_RESET;
				end else if (rx_push[ch]) begin
					rx_full <= 1'b1;
					rx_hold <= rx_byte[ch*8 +: 8];
				end else if (rd_hold) begin
					rx_full <= 1'b0;
				end
			end

			always_comb begin
				msr = 8'h00;
				msr[dua_pkg::MSR_CTS] = !pin_cts_n[ch];
				msr[dua_pkg::MSR_DSR] = !pin_dsr_n[ch];
				msr[dua_pkg::MSR_RI]  = !pin_ri_n[ch];
				msr[dua_pkg::MSR_CD]  = !pin_cd_n[ch];
				case (rd_addr)
					dua_pkg::OFS_HOLDING:      ch_rd_val[ch*8 +: 8] = rx_hold;
					dua_pkg::OFS_INT_ENABLE:   ch_rd_val[ch*8 +: 8] = ier;
					dua_pkg::OFS_ENH_FEATURE:  ch_rd_val[ch*8 +: 8] = enhanced_feature_reg;
					dua_pkg::OFS_MODEM_CTRL:   ch_rd_val[ch*8 +: 8] = modem_control_reg;
					dua_pkg::OFS_MODEM_STATUS: ch_rd_val[ch*8 +: 8] = msr;
					dua_pkg::OFS_IR_CONFIG:    ch_rd_val[ch*8 +: 8] = ircfg;
					default: ch_rd_val[ch*8 +: 8] = mem_bus.rd_data;
				endcase
			end

			assign irq_req[ch] = (ier[dua_pkg::IER_RX] && rx_full) ||
				(ier[dua_pkg::IER_TX] && !tx_full);
			assign tx_allowed[ch] =
				!(enhanced_feature_reg[dua_pkg::EFR_AUTO_CTS] && pin_cts_n[ch]);

			always_ff @(posedge ref_clk) begin
				if (int_rst) begin
					tx_byte[ch*8 +: 8] <= dua_pkg::REG_RESET;
					tx_rdy_n[ch] <= 1'b0;
					rx_rdy_n[ch] <= 1'b1;
					ser_out[ch]  <= 1'b1;
					rx_line[ch]  <= 1'b1;
					rts_n[ch]    <= 1'b1;
					dtr_n[ch]    <= 1'b1;
					op2_n[ch]    <= 1'b1;
				end else begin
					tx_byte[ch*8 +: 8] <= tx_hold;
					tx_rdy_n[ch] <= tx_full;
					rx_rdy_n[ch] <= !rx_full;
					if (modem_control_reg[dua_pkg::MCR_IR]) begin
						ser_out[ch] <= tx_busy[ch] && !tx_bit[ch];
						rx_line[ch] <= pin_serial_in[ch] ^
							ircfg[dua_pkg::IRC_RX_INV];
					end else begin
						ser_out[ch] <= !tx_busy[ch] || tx_bit[ch];
						rx_line[ch] <= pin_serial_in[ch];
					end
					// Automatic control only ever withdraws a request software made.
					rts_n[ch] <= !modem_control_reg[dua_pkg::MCR_RTS] ||
						(enhanced_feature_reg[dua_pkg::EFR_AUTO_RTS] && rx_full);
					dtr_n[ch] <= !modem_control_reg[dua_pkg::MCR_DTR];
					op2_n[ch] <= !modem_control_reg[dua_pkg::MCR_OP2];
				end
			end
		end
	endgenerate

	// Line mode shares one open-drain request on the channel A pin.
	always_ff @(posedge ref_clk) begin
		if (int_rst) begin
			irq_out  <= 2'h0;
			irq_oe_n <= 2'h3;
		end else if (bus_mode_strobe) begin
			irq_out  <= irq_req;
			irq_oe_n <= {!g_ch[1].modem_control_reg[dua_pkg::MCR_OP2],
				!g_ch[0].modem_control_reg[dua_pkg::MCR_OP2]};
		end else begin
			irq_out  <= 2'h0;
			irq_oe_n <= {1'b1, !(irq_req[0] || irq_req[1])};
		end
	end

	assign channel_a_irq_out = irq_out[0];
	assign channel_b_irq_out = irq_out[1];
	assign channel_a_irq_oe_n = irq_oe_n[0];
	assign channel_b_irq_oe_n = irq_oe_n[1];
	assign channel_a_output_port2_n = op2_n[0];
	assign channel_b_output_port2_n = op2_n[1];
	assign channel_a_tx_ready_n = tx_rdy_n[0];
	assign channel_b_tx_ready_n = tx_rdy_n[1];
	assign channel_a_rx_ready_n = rx_rdy_n[0];
	assign channel_b_rx_ready_n = rx_rdy_n[1];
	assign channel_a_serial_out = ser_out[0];
	assign channel_b_serial_out = ser_out[1];
	assign channel_a_request_to_send_n = rts_n[0];
	assign channel_b_request_to_send_n = rts_n[1];
	assign channel_a_terminal_ready_n = dtr_n[0];
	assign channel_b_terminal_ready_n = dtr_n[1];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_mcr_write: assert property (commit && !acc_chan && !int_rst &&
		acc_addr == dua_pkg::OFS_MODEM_CTRL |=> g_ch[0].modem_control_reg == $past(data_q))
		else $error("modem control write not stored");
	a_read_drive: assert property (state == dua_pkg::DUA_IDLE &&
		start_read && !int_rst |=> !data_oe_n)
		else $error("read start did not drive the bus");
	a_bus_quiet: assert property (!data_oe_n && $past(bus_mode_strobe) |->
		!$past(read_strobe_n) && $past(access_sel))
		else $error("bus driven outside a read");
	a_unselected_ignored: assert property (
		state == dua_pkg::DUA_IDLE && !access_sel |=>
		state == dua_pkg::DUA_IDLE)
		else $error("access began without chip select");
	a_line_chan_pick: assert property (!bus_mode_strobe &&
		state == dua_pkg::DUA_IDLE && start_write && !int_rst |=>
		acc_chan == $past(channel_b_select_n))
		else $error("channel address bit misdecoded");
	a_irq_enable: assert property (bus_mode_strobe &&
		!g_ch[0].modem_control_reg[dua_pkg::MCR_OP2] |=>
		channel_a_irq_oe_n && channel_a_output_port2_n)
		else $error("interrupt pin driven while disabled");
	a_shared_irq: assert property (!bus_mode_strobe |=>
		channel_b_irq_oe_n && !channel_a_irq_out)
		else $error("line mode interrupt pins misused");
	a_tx_ready_flag: assert property (commit && !acc_chan && !int_rst &&
		acc_addr == dua_pkg::OFS_HOLDING |=> ##1 channel_a_tx_ready_n)
		else $error("transmit ready stayed asserted after write");
	a_rx_ready_flag: assert property (rx_push[0] && !int_rst |=>
		##1 !channel_a_rx_ready_n)
		else $error("receive ready missing after byte");
	a_std_idle_high: assert property (!g_ch[0].modem_control_reg[dua_pkg::MCR_IR] &&
		!tx_busy[0] |=> channel_a_serial_out)
		else $error("standard line not idle high");
	a_ir_idle_low: assert property (g_ch[0].modem_control_reg[dua_pkg::MCR_IR] &&
		!tx_busy[0] && !int_rst |=> !channel_a_serial_out)
		else $error("infrared line not idle low");
	a_rx_invert: assert property (g_ch[0].modem_control_reg[dua_pkg::MCR_IR] &&
		g_ch[0].ircfg[dua_pkg::IRC_RX_INV] && !int_rst |=>
		rx_line[0] == !$past(channel_a_serial_in))
		else $error("infrared receive not inverted");
	a_auto_cts_gate: assert property (
		g_ch[0].enhanced_feature_reg[dua_pkg::EFR_AUTO_CTS] && $past(channel_a_clear_to_send_n)
		&& channel_a_clear_to_send_n |-> !tx_allowed[0])
		else $error("transmit allowed without clear to send");
	a_dtr_follow: assert property (!int_rst |=>
		channel_a_terminal_ready_n == !$past(g_ch[0].modem_control_reg[dua_pkg::MCR_DTR]))
		else $error("terminal ready does not follow control");
	a_pulse_reset: assert property (
		(bus_mode_strobe && reset_pin) [*5] |=> channel_a_rx_ready_n &&
		channel_a_serial_out)
		else $error("long reset pulse did not reset channel");

	c_strobe_read: cover property (bus_mode_strobe && start_read);
	c_strobe_write: cover property (bus_mode_strobe && commit);
	c_line_write: cover property (!bus_mode_strobe && commit);
	c_ir_mode: cover property (g_ch[0].modem_control_reg[dua_pkg::MCR_IR] && tx_busy[0]);
endmodule // dua_host_port
`default_nettype wire

// *** tb/dua_host_model.sv ***
// Host processor model that runs byte accesses on the parallel bus.
`timescale 1ns/1ps
`default_nettype none
module dua_host_model (
	input  wire logic       ref_clk,
	input  wire logic       line_mode,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe_n,
	output logic      [2:0] addr,
	output var logic  [7:0] data_in,
	output logic            read_strobe_n,
	output logic            write_strobe_n,
	output logic            channel_a_select_n,
	output logic            channel_b_select_n
);
	logic [7:0] drv = 8'h00;
	logic       drv_on = 1'b0;

	// A released bus shows the inverse of the last byte, never a stale copy.
	assign data_in = !data_oe_n ? data_out : (drv_on ? drv : ~drv);

	initial begin
		addr = 3'h0;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		channel_a_select_n = 1'b1;
		channel_b_select_n = 1'b1;
	end

	task automatic access(input logic wr, input logic ch, input logic sel,
		input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge ref_clk);
		addr <= a;
		drv <= d;
		drv_on <= wr;
		if (line_mode) begin
			write_strobe_n <= !wr;
			channel_b_select_n <= ch;
		end else begin
			channel_a_select_n <= !(sel && !ch);
			channel_b_select_n <= !(sel && ch);
		end
		@(posedge ref_clk);
		if (line_mode)
			channel_a_select_n <= !sel;
		else if (wr)
			write_strobe_n <= 1'b0;
		else
			read_strobe_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		q = data_out;
		read_strobe_n <= 1'b1;
		if (line_mode)
			channel_a_select_n <= 1'b1;
		else
			write_strobe_n <= 1'b1;
		@(posedge ref_clk);
		channel_a_select_n <= 1'b1;
		channel_b_select_n <= 1'b1;
		write_strobe_n <= 1'b1;
		drv_on <= 1'b0;
		@(posedge ref_clk);
	endtask
endmodule // dua_host_model
`default_nettype wire

// *** tb/test_dual_uart_host_bus_and_pin_control.sv ***
// Self-checking bench for the dual serial device host port.
`timescale 1ns/1ps
`default_nettype none
module test_dual_uart_host_bus_and_pin_control;
	logic        ref_clk;
	logic        rst_b = 1'b0;
	logic        bus_mode_strobe = 1'b1;
	logic        reset_pin = 1'b0;
	logic [1:0]  tx_taken = 2'h0;
	logic [1:0]  tx_busy = 2'h0;
	logic [1:0]  tx_bit = 2'h0;
	logic [1:0]  rx_push = 2'h0;
	logic [15:0] rx_byte = 16'h0000;
	logic        si_a = 1'b1;
	logic        cts_a = 1'b1;
	logic        dsr_a = 1'b1;
	logic        cd_a = 1'b1;
	logic        ri_a = 1'b1;
	logic [7:0]  data_out, data_in;
	logic [2:0]  addr;
	logic [15:0] tx_byte, s;
	logic [1:0]  tx_allowed, rx_line;
	logic        data_oe_n, read_strobe_n, write_strobe_n;
	logic        channel_a_select_n, channel_b_select_n;
	logic        irq_a, irq_oe_a, irq_b, irq_oe_b, op2_a, op2_b;
	logic        txr_a, txr_b, rxr_a, rxr_b, so_a, so_b;
	logic        rts_a, rts_b, dtr_a, dtr_b;
	int          err_count = 0;
	int          samples_checked = 0;

	dua_host_port dut_u (
		.ref_clk, .rst_b, .bus_mode_strobe, .reset_pin, .addr, .data_in,
		.data_out, .data_oe_n, .read_strobe_n, .write_strobe_n,
		.channel_a_select_n, .channel_b_select_n,
		.channel_a_irq_out(irq_a), .channel_a_irq_oe_n(irq_oe_a),
		.channel_b_irq_out(irq_b), .channel_b_irq_oe_n(irq_oe_b),
		.channel_a_output_port2_n(op2_a),
		.channel_b_output_port2_n(op2_b),
		.channel_a_tx_ready_n(txr_a), .channel_b_tx_ready_n(txr_b),
		.channel_a_rx_ready_n(rxr_a), .channel_b_rx_ready_n(rxr_b),
		.channel_a_serial_out(so_a), .channel_b_serial_out(so_b),
		.channel_a_serial_in(si_a), .channel_b_serial_in(1'b1),
		.channel_a_request_to_send_n(rts_a),
		.channel_b_request_to_send_n(rts_b),
		.channel_a_clear_to_send_n(cts_a),
		.channel_b_clear_to_send_n(1'b1),
		.channel_a_terminal_ready_n(dtr_a),
		.channel_b_terminal_ready_n(dtr_b),
		.channel_a_set_ready_n(dsr_a), .channel_b_set_ready_n(1'b1),
		.channel_a_carrier_detect_n(cd_a),
		.channel_b_carrier_detect_n(1'b1),
		.channel_a_ring_indicator_n(ri_a),
		.channel_b_ring_indicator_n(1'b1),
		.tx_taken, .tx_busy, .tx_bit, .tx_byte, .tx_allowed, .rx_push,
		.rx_byte, .rx_line
	);

	dua_host_model host_u (
		.ref_clk, .line_mode(!bus_mode_strobe), .data_out, .data_oe_n,
		.addr, .data_in, .read_strobe_n, .write_strobe_n,
		.channel_a_select_n, .channel_b_select_n
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic wrap_up;
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	// Pins change two edges after a write, so three edges leave margin.
	task automatic settle;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		host_u.access(1'b1, ch, 1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic ch, input logic [2:0] a,
		input logic [7:0] m, input logic [7:0] want);
		logic [7:0] q;
		host_u.access(1'b0, ch, 1'b1, a, 8'h00, q);
		check({8'h00, q & m}, {8'h00, want});
	endtask

	task automatic t_regs;
		logic [7:0] q;
		wr(1'b0, 3'h3, 8'hA5);
		wr(1'b1, 3'h3, 8'h5A);
		wr(1'b0, 3'h5, 8'hC3);
		host_u.access(1'b1, 1'b0, 1'b0, 3'h3, 8'hFF, q);
		rd_chk(1'b0, 3'h3, 8'hFF, 8'hA5);
		rd_chk(1'b1, 3'h3, 8'hFF, 8'h5A);
		rd_chk(1'b0, 3'h5, 8'hFF, 8'hC3);
	endtask

	task automatic t_mcr;
		wr(1'b0, 3'h4, 8'h0B);
		settle();
		s = 16'({op2_a, irq_oe_a, dtr_a, rts_a, op2_b, irq_oe_b});
		check(s, 16'h0003);
		wr(1'b1, 3'h1, 8'h02);
		settle();
		check(16'({irq_b, irq_a}), 16'h0002);
		wr(1'b0, 3'h4, 8'h00);
		settle();
		check(16'({op2_a, irq_oe_a, dtr_a}), 16'h0007);
	endtask

	task automatic t_txrx;
		wr(1'b1, 3'h0, 8'h3C);
		settle();
		check(16'({txr_b, tx_byte[15:8]}), 16'h013C);
		@(posedge ref_clk);
		tx_taken <= 2'b10;
		@(posedge ref_clk);
		tx_taken <= 2'b00;
		settle();
		check(16'(txr_b), 16'h0000);
		wr(1'b0, 3'h4, 8'h02);
		wr(1'b0, 3'h2, 8'h40);
		@(posedge ref_clk);
		rx_byte <= 16'h0096;
		rx_push <= 2'b01;
		@(posedge ref_clk);
		rx_push <= 2'b00;
		settle();
		check(16'({rxr_a, rts_a}), 16'h0001);
		rd_chk(1'b0, 3'h0, 8'hFF, 8'h96);
		settle();
		check(16'({rxr_a, rts_a}), 16'h0002);
	endtask

	task automatic t_ir;
		wr(1'b0, 3'h4, 8'h40);
		wr(1'b0, 3'h7, 8'h01);
		@(posedge ref_clk);
		si_a <= 1'b0;
		settle();
		check(16'({so_a, so_b, rx_line}), 16'h0007);
		@(posedge ref_clk);
		tx_busy <= 2'b01;
		settle();
		check(16'(so_a), 16'h0001);
		@(posedge ref_clk);
		tx_busy <= 2'b00;
		si_a <= 1'b1;
		wr(1'b0, 3'h4, 8'h00);
		settle();
		check(16'(so_a), 16'h0001);
	endtask

	task automatic t_flow;
		wr(1'b0, 3'h2, 8'h80);
		settle();
		check(16'(tx_allowed), 16'h0002);
		@(posedge ref_clk);
		cts_a <= 1'b0;
		dsr_a <= 1'b0;
		settle();
		check(16'(tx_allowed), 16'h0003);
		rd_chk(1'b0, 3'h6, 8'hF0, 8'h30);
	endtask

	task automatic t_line;
		@(posedge ref_clk);
		bus_mode_strobe <= 1'b0;
		reset_pin <= 1'b1;
		wr(1'b1, 3'h3, 8'h77);
		rd_chk(1'b1, 3'h3, 8'hFF, 8'h77);
		rd_chk(1'b0, 3'h3, 8'hFF, 8'hA5);
		wr(1'b1, 3'h1, 8'h02);
		settle();
		check(16'({irq_a, irq_oe_a, irq_oe_b}), 16'h0001);
		wr(1'b1, 3'h1, 8'h00);
		@(posedge ref_clk);
		bus_mode_strobe <= 1'b1;
		reset_pin <= 1'b0;
	endtask

	task automatic t_rst_pin;
		@(posedge ref_clk);
		reset_pin <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset_pin <= 1'b0;
		rd_chk(1'b0, 3'h3, 8'hFF, 8'hA5);
		reset_pin <= 1'b1;
		repeat (6) @(posedge ref_clk);
		reset_pin <= 1'b0;
		rd_chk(1'b0, 3'h3, 8'hFF, 8'h00);
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		#1;
		s = 16'({data_oe_n, op2_a, op2_b, irq_oe_a, irq_oe_b, txr_a, txr_b,
			rxr_a, rxr_b, so_a, so_b, dtr_a, dtr_b});
		check(s, 16'h1F3F);
		t_regs();
		t_mcr();
		t_txrx();
		t_ir();
		t_flow();
		t_line();
		t_rst_pin();
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		wrap_up();
	end
endmodule // test_dual_uart_host_bus_and_pin_control
`default_nettype wire
